//--- inc/bsp_map.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 10 MHz clock and byte addressing on the register bus.
`ifndef BSP_MAP_SVH
`define BSP_MAP_SVH

`define BSP_OFS_CTRL        4'h0
`define BSP_OFS_STATUS      4'h4

`define BSP_CTRL_PM_LSB     0
`define BSP_CTRL_PM_MSB     2
`define BSP_CTRL_BSIE_BIT   3
`define BSP_CTRL_BATTERY_LOW_IRQ_ENABLE_BIT   4
`define BSP_CTRL_PM_RST     3'h7

`define BSP_ST_BSF_BIT      0
`define BSP_ST_BLF_BIT      1
`define BSP_ST_ONBAT_BIT    2
`define BSP_ST_CMPEN_BIT    3

`define BSP_CLK_MHZ         10
`define BSP_REC_MIN_US      15630
`define BSP_REC_MAX_US      31250
`define BSP_REC_CYCLES      (`BSP_REC_MIN_US * `BSP_CLK_MHZ)

`endif

//--- inc/bsp_pkg.sv
// Types shared by the switch-over and power-fail monitor.
// Assumes nothing beyond the map header.
package bsp_pkg;

   typedef enum logic [1:0] {
      BSP_MODE_STD,
      BSP_MODE_DIRECT,
      BSP_MODE_OFF
   } bsp_mode_e;

   typedef logic [18:0] bsp_cnt_t;

   typedef struct packed {
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [2:0]  pm;
      logic        bsie;
      logic        battery_low_irq_enable;
      logic        bsf;
      logic        battery_low_flag;
      logic        on_bat;
      logic        cmp_en;
      bsp_cnt_t    rec_cnt;
      logic        pfo_low;
      logic        ack;
      logic [31:0] rdata;
   } bsp_state_s;

endpackage

//--- hw/bsp_monitor.sv
// Supply switch-over, battery-low flagging and power-fail output control.
// Assumes asynchronous comparator levels and an Avalon-MM master.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "bsp_map.svh"

module bsp_monitor #(
   parameter int REC_CYCLES = `BSP_REC_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        vdd_below_bat,
   input  wire logic        vdd_below_thr,
   input  wire logic        bat_below_low,
   input  wire logic        pfi_below_ref,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             backed_supply_out,
   output logic             power_fail_out_n_o,
   output logic             power_fail_out_n_oe,
   output logic             irq
);

   localparam int VB = 0;
   localparam int VT = 1;
   localparam int BL = 2;
   localparam int PF = 3;

   bsp_pkg::bsp_state_s st_r;
   bsp_pkg::bsp_state_s st_nxt;
   bsp_pkg::bsp_mode_e  mode;
   logic                bl_en;
   logic                pf_en;
   logic                sel_bat;
   logic                req;
   logic                take;

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   always_comb begin
      case (st_r.pm)
         3'h0, 3'h1, 3'h2: mode = bsp_pkg::BSP_MODE_STD;
         3'h3, 3'h4, 3'h5: mode = bsp_pkg::BSP_MODE_DIRECT;
         default:          mode = bsp_pkg::BSP_MODE_OFF;
      endcase
      bl_en = (st_r.pm == 3'h0) || (st_r.pm == 3'h3);
      pf_en = !((st_r.pm == 3'h2) || (st_r.pm == 3'h5) ||
                (st_r.pm == 3'h7));
      case (mode)
         bsp_pkg::BSP_MODE_STD:    sel_bat = st_r.s2[VB] & st_r.s2[VT];
         bsp_pkg::BSP_MODE_DIRECT: sel_bat = st_r.s2[VB];
         default:                  sel_bat = 1'b0;
      endcase
   end

   assign req  = avs_read | avs_write;
   assign take = req & st_r.ack;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {pfi_below_ref, bat_below_low, vdd_below_thr,
                   vdd_below_bat};
      st_nxt.s2 = st_r.s1;

      // One wait cycle, then the answer; reads are captured early.
      st_nxt.ack = req & ~st_r.ack;
      if (avs_read && !st_r.ack) begin
         st_nxt.rdata = 32'h0;
         if (!st_r.on_bat) begin
            case (avs_address)
               `BSP_OFS_CTRL: begin
                  st_nxt.rdata[`BSP_CTRL_PM_MSB:`BSP_CTRL_PM_LSB] = st_r.pm;
                  st_nxt.rdata[`BSP_CTRL_BSIE_BIT] = st_r.bsie;
                  st_nxt.rdata[`BSP_CTRL_BATTERY_LOW_IRQ_ENABLE_BIT] = st_r.battery_low_irq_enable;
               end
               `BSP_OFS_STATUS: begin
                  st_nxt.rdata[`BSP_ST_BSF_BIT]   = st_r.bsf;
                  st_nxt.rdata[`BSP_ST_BLF_BIT]   = st_r.battery_low_flag;
                  st_nxt.rdata[`BSP_ST_ONBAT_BIT] = st_r.on_bat;
                  st_nxt.rdata[`BSP_ST_CMPEN_BIT] = st_r.cmp_en;
               end
               default: st_nxt.rdata = 32'h0;
            endcase
         end
      end

      if (take && avs_write && !st_r.on_bat && avs_byteenable[0]) begin
         case (avs_address)
            `BSP_OFS_CTRL: begin
               st_nxt.pm   = avs_writedata[`BSP_CTRL_PM_MSB:`BSP_CTRL_PM_LSB];
               st_nxt.bsie = avs_writedata[`BSP_CTRL_BSIE_BIT];
               st_nxt.battery_low_irq_enable = avs_writedata[`BSP_CTRL_BATTERY_LOW_IRQ_ENABLE_BIT];
            end
            `BSP_OFS_STATUS: begin
               if (avs_writedata[`BSP_ST_BSF_BIT]) begin
                  st_nxt.bsf = 1'b0;
               end
            end
            default: st_nxt.pm = st_r.pm;
         endcase
      end

      // The set below overrides a clear issued in the same cycle.
      st_nxt.on_bat = sel_bat;
      if (sel_bat && !st_r.on_bat) begin
         st_nxt.bsf = 1'b1;
      end
      if (mode == bsp_pkg::BSP_MODE_OFF) begin
         st_nxt.bsf = 1'b0;
      end

      // Follows the comparator on either supply when pm is 0 or 3, else held at 0; no software path exists.
      st_nxt.battery_low_flag = bl_en & st_r.s2[BL];

      if (sel_bat) begin
         st_nxt.cmp_en  = 1'b0;
         st_nxt.rec_cnt = '0;
      end else if (st_r.on_bat) begin
         st_nxt.rec_cnt = bsp_pkg::bsp_cnt_t'(REC_CYCLES);
      end else if (st_r.rec_cnt != '0) begin
         st_nxt.rec_cnt = st_r.rec_cnt - 19'h1;
         if (st_r.rec_cnt == 19'h1) begin
            st_nxt.cmp_en = 1'b1;
         end
      end

      // The comparator result counts only once recovery has finished.
      st_nxt.pfo_low = sel_bat |
                       (~st_r.on_bat & st_r.cmp_en & pf_en &
                        st_r.s2[PF]);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r        <= '0;
         st_r.pm     <= `BSP_CTRL_PM_RST;
         st_r.cmp_en <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_waitrequest     = req & ~st_r.ack;
   assign avs_readdata        = st_r.rdata;
   assign backed_supply_out   = st_r.on_bat;
   assign power_fail_out_n_o  = 1'b0;
   assign power_fail_out_n_oe = st_r.pfo_low;
   assign irq = (st_r.bsf & st_r.bsie) | (st_r.battery_low_flag & st_r.battery_low_irq_enable);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_std;
      (st_r.pm <= 3'h2) |=> st_r.on_bat == $past(st_r.s2[VB] & st_r.s2[VT]);
   endproperty
   a_std: assert property (p_std) else $error("standard select wrong");

   property p_direct;
      (st_r.pm >= 3'h3 && st_r.pm <= 3'h5) |=>
         st_r.on_bat == $past(st_r.s2[VB]);
   endproperty
   a_direct: assert property (p_direct) else $error("direct select wrong");

   property p_off;
      (st_r.pm >= 3'h6) |=> (!st_r.bsf && !backed_supply_out);
   endproperty
   a_off: assert property (p_off) else $error("disabled mode not on main");

   property p_bl_set;
      (st_r.s2[BL] && (st_r.pm == 3'h0 || st_r.pm == 3'h3)) |=> st_r.battery_low_flag;
   endproperty
   a_bl_set: assert property (p_bl_set) else $error("battery low not set");

   property p_bl_clr;
      !st_r.s2[BL] |=> !st_r.battery_low_flag;
   endproperty
   a_bl_clr: assert property (p_bl_clr) else $error("battery low stuck");

   property p_bl_irq;
      (st_r.battery_low_flag && !st_r.battery_low_irq_enable && !st_r.bsf) |-> !irq;
   endproperty
   a_bl_irq: assert property (p_bl_irq) else $error("masked irq raised");

   property p_bsf_set;
      $rose(st_r.on_bat) |-> (st_r.bsf && power_fail_out_n_oe && !st_r.cmp_en);
   endproperty
   a_bsf_set: assert property (p_bsf_set) else $error("switch entry wrong");

   property p_rec;
      $fell(st_r.on_bat) |-> (!st_r.cmp_en &&
         st_r.rec_cnt == bsp_pkg::bsp_cnt_t'(REC_CYCLES));
   endproperty
   a_rec: assert property (p_rec) else $error("recovery not started");

   property p_rec_done;
      (st_r.rec_cnt == 19'h1) |=> (st_r.cmp_en || st_r.on_bat);
   endproperty
   a_rec_done: assert property (p_rec_done) else $error("comparator not back");

   property p_pfo;
      (!st_r.on_bat && st_r.cmp_en && pf_en && st_r.s2[PF] && !sel_bat)
         |=> power_fail_out_n_oe;
   endproperty
   a_pfo: assert property (p_pfo) else $error("power fail not driven");

   property p_bus_bat;
      (take && avs_write && st_r.on_bat) |=> $stable(st_r.pm);
   endproperty
   a_bus_bat: assert property (p_bus_bat) else $error("write on battery");

   // ------------------------------------------------------------
   // Bus, flag and recovery checks
   // ------------------------------------------------------------
   // These guard the paths that the scenario checks reach only
   // indirectly: masked writes, hold of the flags between events and
   // the quiet interval of the comparator after a return to main.

   property p_answer;
      (req && !st_r.ack) |=> (!req || !avs_waitrequest);
   endproperty
   a_answer: assert property (p_answer) else $error("no bus answer");

   property p_rd_bat;
      (avs_read && !st_r.ack && st_r.on_bat) |=> (avs_readdata == 32'h0);
   endproperty
   a_rd_bat: assert property (p_rd_bat) else $error("read on battery");

   property p_ie_bat;
      (take && avs_write && st_r.on_bat) |=>
         ($stable(st_r.bsie) && $stable(st_r.battery_low_irq_enable));
   endproperty
   a_ie_bat: assert property (p_ie_bat) else $error("enable on battery");

   property p_bsf_clr;
      (take && avs_write && !st_r.on_bat && avs_byteenable[0] &&
       avs_address == `BSP_OFS_STATUS && avs_writedata[0] && !sel_bat)
         |=> !st_r.bsf;
   endproperty
   a_bsf_clr: assert property (p_bsf_clr) else $error("flag not cleared");

   property p_bsf_hold;
      (st_r.bsf && st_r.pm < 3'h6 && !take) |=> st_r.bsf;
   endproperty
   a_bsf_hold: assert property (p_bsf_hold) else $error("flag lost");

   property p_irq_bs;
      (st_r.bsf && st_r.bsie) |-> irq;
   endproperty
   a_irq_bs: assert property (p_irq_bs) else $error("switch irq missing");

   property p_irq_bl;
      (st_r.battery_low_flag && st_r.battery_low_irq_enable) |-> irq;
   endproperty
   a_irq_bl: assert property (p_irq_bl) else $error("low irq missing");

   property p_blf_mask;
      !bl_en |=> !st_r.battery_low_flag;
   endproperty
   a_blf_mask: assert property (p_blf_mask) else $error("low flag unmasked");

   property p_cmp_bat;
      st_r.on_bat |-> (!st_r.cmp_en && power_fail_out_n_oe);
   endproperty
   a_cmp_bat: assert property (p_cmp_bat) else $error("comparator on");

   property p_rel;
      $fell(st_r.on_bat) |-> !power_fail_out_n_oe;
   endproperty
   a_rel: assert property (p_rel) else $error("fail pin not released");

   property p_rec_hold;
      (!st_r.cmp_en && st_r.rec_cnt > 19'h1) |=> !st_r.cmp_en;
   endproperty
   a_rec_hold: assert property (p_rec_hold) else $error("early enable");

   property p_quiet;
      (!st_r.on_bat && !st_r.cmp_en && !sel_bat) |=> !power_fail_out_n_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("pin low in recovery");

   property p_sync;
      st_r.s2 == $past(st_r.s1);
   endproperty
   a_sync: assert property (p_sync) else $error("sync stage skipped");

endmodule

//--- verif/bsp_cmp_model.sv
// Comparator front end that feeds the monitor, driven by millivolt levels.
// Assumes the bench sets the supply levels; outputs are plain levels.
`timescale 1ns/1ps
module bsp_cmp_model #(
   parameter int THR_MV = 2500,
   parameter int LOW_MV = 2500,
   parameter int REF_MV = 1250
) (
   input  wire logic [12:0] vdd_mv,
   input  wire logic [12:0] vbat_mv,
   input  wire logic [12:0] vpfi_mv,
   output logic             vdd_below_bat,
   output logic             vdd_below_thr,
   output logic             bat_below_low,
   output logic             pfi_below_ref
);
   // Ideal comparators without hysteresis; the bench keeps vdd and vpfi off equal levels.
   assign vdd_below_bat = vdd_mv < vbat_mv;
   assign vdd_below_thr = vdd_mv < 13'(THR_MV);
   assign bat_below_low = vbat_mv < 13'(LOW_MV);
   assign pfi_below_ref = vpfi_mv < 13'(REF_MV);
endmodule

//--- verif/tb.sv
// Self-checking bench for the switch-over and power-fail monitor.
// Assumes the comparator model in front and a pull-up on the fail pin.
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [12:0] vdd = 13'h0CE4, vbat = 13'h0AF0, vpfi = 13'h05DC;
   logic [3:0]  adr = 4'h0, be = 4'hF;
   logic        rd = 1'b0, wr = 1'b0;
   logic [31:0] wd = 32'h0, d, rdat;
   logic        wreq, bso, pf_o, pf_oe, irq, c_bb, c_bt, c_bl, c_pf, pin;
   int          n_errors = 0, samples_checked = 0, pm = 7, ie = 0;
   int          bsf = 0, onbat = 0, bat = 0, battery_low_flag = 0, k;

   always #50 clk = ~clk;
   // The fail pin is open drain; the pull-up gives high when released.
   assign pin = pf_oe ? pf_o : 1'b1;

   bsp_cmp_model u_bsp_cmp_model (.vdd_mv(vdd), .vbat_mv(vbat),
      .vpfi_mv(vpfi), .vdd_below_bat(c_bb), .vdd_below_thr(c_bt),
      .bat_below_low(c_bl), .pfi_below_ref(c_pf));
   bsp_monitor #(.REC_CYCLES(20)) u_bsp_monitor (.clk(clk), .resetn(resetn),
      .vdd_below_bat(c_bb), .vdd_below_thr(c_bt), .bat_below_low(c_bl),
      .pfi_below_ref(c_pf), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .backed_supply_out(bso),
      .power_fail_out_n_o(pf_o), .power_fail_out_n_oe(pf_oe), .irq(irq));

   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Called just after a rising edge; the request is held until the
   // rising edge at which waitrequest is seen low, then released.
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] v);
      adr <= a;
      wd <= v;
      rd <= ~w;
      wr <= w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      d = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      if (k >= 50) begin
         n_errors++;
         final_report();
      end
   endtask

   // Reference model of one supply step, then every result compared.
   task automatic supply(input int v, input int b, input int p);
      int was;
      was = onbat;
      vdd <= 13'(v);
      vbat <= 13'(b);
      vpfi <= 13'(p);
      bat = (pm < 6 && v < b && (pm > 2 || v < 2500)) ? 1 : 0;
      battery_low_flag = ((pm == 0 || pm == 3) && b < 2500) ? 1 : 0;
      if (bat == 1 && was == 0)
         bsf = 1;
      onbat = bat;
      repeat (5) @(posedge clk);
      if (was == 1 && bat == 0) begin
         chk("pin_recovery", 1, pin);
         repeat (30) @(posedge clk);
      end
      chk("backed", bat, bso);
      chk("pin", (bat == 1 || (p < 1250 && pm != 2 && pm != 5 && pm != 7))
          ? 0 : 1, pin);
      chk("irq", ((bsf & ie) | (battery_low_flag & (ie >> 1))) & 1, irq);
      bus(1'b0, 4'h4, 32'h0);
      chk("status", bat ? 0 : (battery_low_flag << 1) | bsf, d & 32'h7);
      if (bat == 0) begin
         bus(1'b1, 4'h4, 32'h3);
         bsf = 0;
         bus(1'b0, 4'h4, 32'h0);
         chk("status_clr", battery_low_flag << 1, d & 32'h7);
         chk("irq_clr", battery_low_flag & (ie >> 1) & 1, irq);
      end
   endtask

   initial begin
      void'($urandom(87055));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl_reset", 32'h7, d);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, d);
      for (pm = 0; pm < 8; pm++) begin
         ie = pm % 4;
         bus(1'b1, 4'h0, 32'(pm | (ie << 3)));
         bus(1'b0, 4'h0, 32'h0);
         chk("ctrl", pm | (ie << 3), d);
         supply(1500, 2800, 1000);
         if (bat == 1)
            bus(1'b1, 4'h0, 32'h0);
         supply(3300, 2300, 1000);
         bus(1'b0, 4'h0, 32'h0);
         chk("ctrl_kept", pm | (ie << 3), d);
         repeat (4)
            supply(1501 + 2 * ($urandom % 1000), 2000 + 2 * ($urandom % 500),
                   1001 + 2 * ($urandom % 250));
         supply(3300, 2800, 1500);
      end
      final_report();
   end
endmodule
